/* File: dv/rbc_supply_model.sv */
`timescale 1ns/100ps
`include "rbc_defs.svh"
// ----------------------------------------
// board reset network and supply monitor
// ----------------------------------------
module rbc_supply_model (
    input  wire logic clk_sys_i,
    output logic      rst_pin_o,
    output logic      por_det_o,
    output logic      bod_low_o
);
    // the rc network holds the pin high from the first moment of power
    initial begin
        rst_pin_o = 1'b1;
        por_det_o = 1'b1;
        bod_low_o = 1'b0;
    end
    // pin stays high past oscillator start plus two machine cycles
    task automatic power_up();
        repeat (`RBC_RST_CLKS) @(posedge clk_sys_i);
        por_det_o <= 1'b0;
        repeat (`RBC_RST_CLKS) @(posedge clk_sys_i);
        rst_pin_o <= 1'b0;
    endtask
    // never shorter than the minimum width, whatever is asked
    task automatic pin_reset(input int clks);
        @(posedge clk_sys_i);
        rst_pin_o <= 1'b1;
        repeat ((clks < `RBC_RST_CLKS) ? `RBC_RST_CLKS : clks) @(posedge clk_sys_i);
        rst_pin_o <= 1'b0;
    endtask
    task automatic set_low(input logic v);
        @(posedge clk_sys_i);
        bod_low_o <= v;
    endtask
    task automatic dip(input int clks);
        set_low(1'b1);
        repeat (clks) @(posedge clk_sys_i);
        bod_low_o <= 1'b0;
    endtask
endmodule

/* File: dv/rbc_top_tb.sv */
`timescale 1ns/100ps
`include "rbc_defs.svh"
module rbc_top_tb;
    logic        clk_sys_i, rst_n_i, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, sys_rst_o, cpu_run_o, fetch_load_o, ram_clear_o;
    logic        sfr_reset_o, ale_pull_o, prog_store_enable_n_pull, port_pull_o, bod_irq_o, irq_o;
    logic [15:0] fetch_addr_o;
    wire         rst_pin, por_det, bod_low;
    int          num_errors = 0;
    int          samples_checked = 0;
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    rbc_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rst_pin_i(rst_pin),
        .por_det_i(por_det), .bod_low_i(bod_low), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sys_rst_o(sys_rst_o), .cpu_run_o(cpu_run_o),
        .fetch_addr_o(fetch_addr_o), .fetch_load_o(fetch_load_o), .ram_clear_o(ram_clear_o),
        .sfr_reset_o(sfr_reset_o), .ale_pull_o(ale_pull_o),
        .prog_store_enable_n_pull_o(prog_store_enable_n_pull), .port_pull_o(port_pull_o),
        .bod_irq_o(bod_irq_o), .irq_o(irq_o));
    rbc_supply_model partner (.clk_sys_i(clk_sys_i), .rst_pin_o(rst_pin),
        .por_det_o(por_det), .bod_low_o(bod_low));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // the request stands until pready is seen at an edge; read data is taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) num_errors++;
        rd = prdata;
        chk("pslverr", 32'h0, {31'h0, pslverr});
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdm(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd & m);
    endtask
    task automatic wait_load(input int lim, input logic [15:0] vec);
        int i;
        i = 0;
        do begin
            @(posedge clk_sys_i);
            #1 i++;
        end while (fetch_load_o !== 1'b1 && i < lim);
        chk("fetch_load_o", 32'h1, {31'h0, fetch_load_o});
        chk("fetch_addr_o", {16'h0, vec}, {16'h0, fetch_addr_o});
    endtask
    // a reset or a reload here would mean a spurious trigger
    task automatic wait_quiet(input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge clk_sys_i);
            #1 if (sys_rst_o !== 1'b0 || fetch_load_o !== 1'b0) bad = 1'b1;
        end
        chk("quiet run", 32'h0, {31'h0, bad});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up();
        #1 chk("pulls", 32'hf, {28'h0, sys_rst_o, ale_pull_o, prog_store_enable_n_pull, port_pull_o});
        partner.power_up();
        wait_load(200, `RBC_RESET_VEC);
        rdm("pof", `RBC_ADDR_POWER_CONTROL_REG, 32'h10, 32'h10);
        rdm("iea", `RBC_ADDR_IEA, 32'hff, {24'h0, `RBC_IEA_RST});
        rdm("flash_config_reg", `RBC_ADDR_FLASH_CONFIG_REG, 32'hff, {24'h0, `RBC_FLASH_CONFIG_REG_RST});
        rdm("watchdog_control_reg", `RBC_ADDR_WATCHDOG_CONTROL_REG, 32'hff, {24'h0, `RBC_WATCHDOG_CONTROL_REG_RST});
        rdm("status por", `RBC_ADDR_ISTAT, 32'h2, 32'h2);
        rdm("unmapped", 12'hff0, 32'hffff_ffff, 32'h0);
    endtask
    task automatic t_pin_reset();
        partner.pin_reset(40);
        #1 chk("pin pulls", 32'h3, {30'h0, sys_rst_o, ale_pull_o});
        wait_load(20, `RBC_RESET_VEC);
        chk("ram_clear_o", 32'h0, {31'h0, ram_clear_o});
        rdm("pof kept", `RBC_ADDR_POWER_CONTROL_REG, 32'h10, 32'h10);
        apb(1'b1, `RBC_ADDR_POWER_CONTROL_REG, 32'h0);
        rdm("pof clear", `RBC_ADDR_POWER_CONTROL_REG, 32'h10, 32'h0);
    endtask
    task automatic t_soft_reset();
        apb(1'b1, `RBC_ADDR_WATCHDOG_CONTROL_REG, 32'h04);
        apb(1'b1, `RBC_ADDR_IEA, 32'h08);
        apb(1'b1, `RBC_ADDR_FLASH_CONFIG_REG, 32'h02);
        wait_load(100, `RBC_RESET_VEC);
        rdm("swr kept", `RBC_ADDR_FLASH_CONFIG_REG, 32'h02, 32'h02);
        rdm("watchdog_status_bit kept", `RBC_ADDR_WATCHDOG_CONTROL_REG, 32'h04, 32'h04);
        rdm("iea reset", `RBC_ADDR_IEA, 32'hff, 32'h0);
        // bit already one: a repeat write is no rising edge
        apb(1'b1, `RBC_ADDR_FLASH_CONFIG_REG, 32'h02);
        wait_quiet(30);
        apb(1'b1, `RBC_ADDR_FLASH_CONFIG_REG, 32'h0);
    endtask
    task automatic t_bod_reset();
        partner.dip(3);
        wait_quiet(15);
        partner.dip(6);
        wait_load(30, `RBC_RESET_VEC);
    endtask
    task automatic t_bod_irq();
        apb(1'b1, `RBC_ADDR_IMASK, 32'h10);
        apb(1'b1, `RBC_ADDR_IEA, 32'h08);
        apb(1'b0, `RBC_ADDR_ISTAT, 32'h0);
        partner.set_low(1'b1);
        wait_load(30, `RBC_BOD_VEC);
        chk("irq run", 32'h7, {29'h0, bod_irq_o, cpu_run_o, irq_o});
        apb(1'b1, `RBC_ADDR_IMASK, 32'h0);
        #1 chk("irq masked", 32'h0, {31'h0, irq_o});
        apb(1'b1, `RBC_ADDR_IMASK, 32'h10);
        rdm("status bod", `RBC_ADDR_ISTAT, 32'h10, 32'h10);
        partner.set_low(1'b0);
        wait_quiet(10);
        chk("irq drop", 32'h0, {31'h0, bod_irq_o});
        rdm("status clr", `RBC_ADDR_ISTAT, 32'h1f, 32'h0);
        #1 chk("irq clr", 32'h0, {31'h0, irq_o});
        apb(1'b1, `RBC_ADDR_IEA, 32'h0);
    endtask
    task automatic t_bod_clear_active();
        apb(1'b1, `RBC_ADDR_IEA, 32'h08);
        partner.set_low(1'b1);
        repeat (15) @(posedge clk_sys_i);
        #1 chk("pending", 32'h1, {31'h0, bod_irq_o});
        apb(1'b1, `RBC_ADDR_IEA, 32'h0);
        repeat (3) @(posedge clk_sys_i);
        #1 chk("full reset", 32'h1, {31'h0, sys_rst_o});
        partner.set_low(1'b0);
        wait_load(40, `RBC_RESET_VEC);
    endtask
    // the block's own reset in mid-run acts as a fresh power-up of the logic
    task automatic t_core_reset();
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1 chk("core rst", 32'h7, {29'h0, sys_rst_o, port_pull_o, sfr_reset_o});
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        wait_load(20, `RBC_RESET_VEC);
        rdm("pof core", `RBC_ADDR_POWER_CONTROL_REG, 32'h10, 32'h10);
        rdm("status core", `RBC_ADDR_ISTAT, 32'h2, 32'h2);
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // the whole sequence needs well under 5000 cycles
    initial begin
        #(40 * 20000);
        num_errors++;
        report_and_stop();
    end
    initial begin
        rst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0;
        repeat (6) @(posedge clk_sys_i);
        #1 chk("rst pull", 32'h1, {31'h0, ale_pull_o});
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_power_up();
        t_pin_reset();
        t_soft_reset();
        t_bod_reset();
        t_bod_irq();
        t_bod_clear_active();
        t_core_reset();
        report_and_stop();
    end
endmodule

/* File: inc/rbc_defs.svh */
// Summary of operation
// - after any system reset execution starts at address 0000h.
// - address latch strobe and program store enable pulled high during reset.
// - a reset while running leaves internal ram untouched.
// - leaving reset, every special function register holds its reset value, except the request bit, watchdog status and power-on flag.
// - power-up reset sequence weakly pulls every port pin high.
// - power-on flag set at power-up, kept until software clears it.
// - soft reset starts when flash config bit 1 rises from 0 to 1.
// - soft reset clears pc and registers, keeps request bit, watchdog status, ram.
// - brown-out acts only after low supply persists four oscillator clocks.
// - with brown-out interrupt disabled, brown-out resets and resumes at 0000h.
// - brown-out interrupt enable is bit 3 of aux enable register at e8h.
// - with enable set, brown-out requests interrupt to vector 004bh.
// - pending or serviced brown-out interrupt lets the processor keep running.
// - clearing the enable while brown-out persists causes a full reset.
// - a machine cycle is 12 oscillator clocks; reset widths scale with it.
`ifndef RBC_DEFS_SVH
`define RBC_DEFS_SVH
`define RBC_CLK_PER_MC      4'd12
`define RBC_RST_MC          2'd2
`define RBC_RST_CLKS        5'd24
`define RBC_SYNC_RST        3'h2
`define RBC_BOD_CLKS        3'd4
`define RBC_RESET_VEC       16'h0000
`define RBC_BOD_VEC         16'h004b
`define RBC_ADDR_IEA        12'h0e8
`define RBC_ADDR_POWER_CONTROL_REG       12'h087
`define RBC_ADDR_FLASH_CONFIG_REG       12'h0b1
`define RBC_ADDR_WATCHDOG_CONTROL_REG       12'h0c0
`define RBC_ADDR_ISTAT      12'h100
`define RBC_ADDR_IMASK      12'h104
`define RBC_ADDR_STATE      12'h108
`define RBC_BIT_EBO         3
`define RBC_BIT_POF         4
`define RBC_BIT_SWR         1
`define RBC_BIT_WATCHDOG_STATUS_BIT        2
`define RBC_IEA_RST         8'h00
`define RBC_POWER_CONTROL_REG_RST        8'h00
`define RBC_FLASH_CONFIG_REG_RST        8'h00
`define RBC_WATCHDOG_CONTROL_REG_RST        8'h00
`define RBC_EV_PIN          0
`define RBC_EV_POR          1
`define RBC_EV_SOFT         2
`define RBC_EV_BOD_RST      3
`define RBC_EV_BOD_IRQ      4
`define RBC_EV_W            5
`endif

/* File: inc/rbc_filt_if.sv */
`timescale 1ns/100ps
// carries one synchronised level and its filtered result
interface rbc_filt_if;
    logic raw;
    logic hit;
    modport flt (input raw, output hit);
    modport usr (output raw, input hit);
endinterface

/* File: inc/rbc_pkg.sv */
package rbc_pkg;
    typedef enum logic [1:0] {
        RBC_ST_POR,
        RBC_ST_HOLD,
        RBC_ST_RUN
    } rbc_state_t;
endpackage

/* File: rtl/rbc_filter.sv */
`timescale 1ns/100ps
`include "rbc_defs.svh"
// ----------------------------------------
// persistence filter
// ----------------------------------------
module rbc_filter (
    input  wire logic   clk_sys_i,
    input  wire logic   rst_n_i,
    rbc_filt_if.flt     f
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;

    always_comb begin
        cnt_nxt = 3'h0;
        if (f.raw) begin
            cnt_nxt = (cnt_r == `RBC_BOD_CLKS) ? cnt_r : cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign f.hit = (cnt_r == `RBC_BOD_CLKS);

    a_bod_persist: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(f.hit) |-> $past(f.raw, 1) && $past(f.raw, 2) && $past(f.raw, 3) && $past(f.raw, 4))
        else $error("brown-out accepted too early");
endmodule

/* File: rtl/rbc_top.sv */
`timescale 1ns/100ps
`include "rbc_defs.svh"
module rbc_top (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        rst_pin_i,
    input  wire logic        por_det_i,
    input  wire logic        bod_low_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             sys_rst_o,
    output logic             cpu_run_o,
    output logic [15:0]      fetch_addr_o,
    output logic             fetch_load_o,
    output logic             ram_clear_o,
    output logic             sfr_reset_o,
    output logic             ale_pull_o,
    output logic             prog_store_enable_n_pull_o,
    output logic             port_pull_o,
    output logic             bod_irq_o,
    output logic             irq_o
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            // power detector reads as asserted until seen low: no false release
            s1_r <= `RBC_SYNC_RST;
            s2_r <= `RBC_SYNC_RST;
        end else begin
            s1_r <= {bod_low_i, por_det_i, rst_pin_i};
            s2_r <= s1_r;
        end
    end
    logic pin_s, por_s;
    assign pin_s = s2_r[0];
    assign por_s = s2_r[1];

    rbc_filt_if bod_f ();
    assign bod_f.raw = s2_r[2];
    rbc_filter u_filt (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .f         (bod_f)
    );
    logic bod_hit;
    assign bod_hit = bod_f.hit;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] iea_r, iea_nxt;
    logic [7:0] power_control_reg_r, power_control_reg_nxt;
    logic [7:0] flash_config_reg_r, flash_config_reg_nxt;
    logic [7:0] watchdog_control_reg_r, watchdog_control_reg_nxt;
    logic [4:0] istat_r, istat_nxt;
    logic [4:0] imask_r, imask_nxt;
    logic [4:0] pin_cnt_r, pin_cnt_nxt;
    logic       pin_ok_r, pin_ok_nxt;
    logic       bod_pend_r, bod_pend_nxt;
    logic       swr_d_r, swr_d_nxt;
    logic       sys_rst_r, sys_rst_nxt;
    logic       load_r, load_nxt;
    logic [15:0] vec_r, vec_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic       rd_done_r, rd_done_nxt;
    rbc_pkg::rbc_state_t st_r, st_nxt;

    logic wr, rd, soft_req, bod_rst, bod_irq, any_rst, brownout_irq_enable;
    assign wr  = psel && penable && pwrite;
    assign rd  = psel && penable && !pwrite;
    assign brownout_irq_enable = iea_r[`RBC_BIT_EBO];
    assign soft_req = flash_config_reg_r[`RBC_BIT_SWR] && !swr_d_r;
    // brown-out resets while disabled, including enable cleared mid-event
    assign bod_rst  = bod_hit && !brownout_irq_enable;
    assign bod_irq  = bod_hit && brownout_irq_enable && !bod_pend_r;
    assign any_rst  = pin_ok_r || por_s || soft_req || bod_rst;

    // ----------------------------------------
    // reset sequencing
    // ----------------------------------------
    always_comb begin
        pin_cnt_nxt = pin_s ? ((pin_cnt_r == `RBC_RST_CLKS) ? pin_cnt_r
                                                            : pin_cnt_r + 5'h1) : 5'h0;
        pin_ok_nxt  = pin_s && (pin_cnt_r >= `RBC_RST_CLKS - 5'h1);
        st_nxt      = st_r;
        sys_rst_nxt = sys_rst_r;
        load_nxt    = 1'b0;
        vec_nxt     = vec_r;
        case (st_r)
            rbc_pkg::RBC_ST_POR: begin
                if (!por_s) begin
                    st_nxt = rbc_pkg::RBC_ST_HOLD;
                end
            end
            rbc_pkg::RBC_ST_HOLD: begin
                if (!any_rst && !pin_s) begin
                    st_nxt      = rbc_pkg::RBC_ST_RUN;
                    sys_rst_nxt = 1'b0;
                    load_nxt    = 1'b1;
                    vec_nxt     = `RBC_RESET_VEC;
                end
            end
            rbc_pkg::RBC_ST_RUN: begin
                if (any_rst) begin
                    st_nxt      = rbc_pkg::RBC_ST_HOLD;
                    sys_rst_nxt = 1'b1;
                end else if (bod_irq) begin
                    load_nxt = 1'b1;
                    vec_nxt  = `RBC_BOD_VEC;
                end
            end
            default: begin
                st_nxt      = rbc_pkg::RBC_ST_POR;
                sys_rst_nxt = 1'b1;
            end
        endcase
        if (por_s) begin
            st_nxt      = rbc_pkg::RBC_ST_POR;
            sys_rst_nxt = 1'b1;
        end
    end

    // ----------------------------------------
    // register file and apb
    // ----------------------------------------
    logic rd_istat;
    logic [4:0] ev;
    assign rd_istat = rd && !rd_done_r && (paddr == `RBC_ADDR_ISTAT);
    always_comb begin
        ev = 5'h0;
        ev[`RBC_EV_PIN]     = pin_ok_r && st_r == rbc_pkg::RBC_ST_RUN;
        ev[`RBC_EV_POR]     = st_r == rbc_pkg::RBC_ST_POR && !por_s;
        ev[`RBC_EV_SOFT]    = soft_req;
        ev[`RBC_EV_BOD_RST] = bod_rst && st_r == rbc_pkg::RBC_ST_RUN;
        ev[`RBC_EV_BOD_IRQ] = bod_irq;
    end

    always_comb begin
        iea_nxt    = iea_r;
        power_control_reg_nxt   = power_control_reg_r;
        flash_config_reg_nxt   = flash_config_reg_r;
        watchdog_control_reg_nxt   = watchdog_control_reg_r;
        imask_nxt  = imask_r;
        swr_d_nxt  = flash_config_reg_r[`RBC_BIT_SWR];
        bod_pend_nxt = (bod_pend_r || bod_irq) && bod_hit;
        istat_nxt  = (rd_istat ? 5'h0 : istat_r) | ev;                    // set beats clear
        prdata_nxt = prdata_r;
        rd_done_nxt = rd && !rd_done_r;
        if (wr) begin
            case (paddr)
                `RBC_ADDR_IEA:   iea_nxt   = pwdata[7:0];
                `RBC_ADDR_POWER_CONTROL_REG:  power_control_reg_nxt  = pwdata[7:0];
                `RBC_ADDR_FLASH_CONFIG_REG:  flash_config_reg_nxt  = pwdata[7:0];
                `RBC_ADDR_WATCHDOG_CONTROL_REG:  watchdog_control_reg_nxt  = pwdata[7:0];
                `RBC_ADDR_IMASK: imask_nxt = pwdata[4:0];
                default: ;
            endcase
        end
        if (rd && !rd_done_r) begin
            case (paddr)
                `RBC_ADDR_IEA:   prdata_nxt = {24'h0, iea_r};
                `RBC_ADDR_POWER_CONTROL_REG:  prdata_nxt = {24'h0, power_control_reg_r};
                `RBC_ADDR_FLASH_CONFIG_REG:  prdata_nxt = {24'h0, flash_config_reg_r};
                `RBC_ADDR_WATCHDOG_CONTROL_REG:  prdata_nxt = {24'h0, watchdog_control_reg_r};
                `RBC_ADDR_ISTAT: prdata_nxt = {27'h0, istat_r};
                `RBC_ADDR_IMASK: prdata_nxt = {27'h0, imask_r};
                `RBC_ADDR_STATE: prdata_nxt = {27'h0, bod_pend_r, bod_hit, pin_s,
                                              sys_rst_r, cpu_run_o};
                default:         prdata_nxt = 32'h0;
            endcase
        end
        // sfr restore keeps the request bit and watchdog status
        if (sys_rst_r) begin
            iea_nxt  = `RBC_IEA_RST;
            flash_config_reg_nxt = (`RBC_FLASH_CONFIG_REG_RST & ~(8'h01 << `RBC_BIT_SWR))
                       | (flash_config_reg_r & (8'h01 << `RBC_BIT_SWR));
            watchdog_control_reg_nxt = (`RBC_WATCHDOG_CONTROL_REG_RST & ~(8'h01 << `RBC_BIT_WATCHDOG_STATUS_BIT))
                       | (watchdog_control_reg_r & (8'h01 << `RBC_BIT_WATCHDOG_STATUS_BIT));
            imask_nxt = imask_r;
            power_control_reg_nxt = (`RBC_POWER_CONTROL_REG_RST & ~(8'h01 << `RBC_BIT_POF))
                       | (power_control_reg_r & (8'h01 << `RBC_BIT_POF));
        end
        if (por_s) begin
            power_control_reg_nxt[`RBC_BIT_POF] = 1'b1;
            flash_config_reg_nxt = `RBC_FLASH_CONFIG_REG_RST;
            watchdog_control_reg_nxt = `RBC_WATCHDOG_CONTROL_REG_RST;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            iea_r      <= `RBC_IEA_RST;
            power_control_reg_r     <= `RBC_POWER_CONTROL_REG_RST;
            flash_config_reg_r     <= `RBC_FLASH_CONFIG_REG_RST;
            watchdog_control_reg_r     <= `RBC_WATCHDOG_CONTROL_REG_RST;
            istat_r    <= 5'h0;
            imask_r    <= 5'h0;
            pin_cnt_r  <= 5'h0;
            pin_ok_r   <= 1'b0;
            bod_pend_r <= 1'b0;
            swr_d_r    <= 1'b0;
            sys_rst_r  <= 1'b1;
            load_r     <= 1'b0;
            vec_r      <= `RBC_RESET_VEC;
            prdata_r   <= 32'h0;
            rd_done_r  <= 1'b0;
            st_r       <= rbc_pkg::RBC_ST_POR;
        end else begin
            iea_r      <= iea_nxt;
            power_control_reg_r     <= power_control_reg_nxt;
            flash_config_reg_r     <= flash_config_reg_nxt;
            watchdog_control_reg_r     <= watchdog_control_reg_nxt;
            istat_r    <= istat_nxt;
            imask_r    <= imask_nxt;
            pin_cnt_r  <= pin_cnt_nxt;
            pin_ok_r   <= pin_ok_nxt;
            bod_pend_r <= bod_pend_nxt;
            swr_d_r    <= swr_d_nxt;
            sys_rst_r  <= sys_rst_nxt;
            load_r     <= load_nxt;
            vec_r      <= vec_nxt;
            prdata_r   <= prdata_nxt;
            rd_done_r  <= rd_done_nxt;
            st_r       <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // read data is registered, so a read costs one wait state
    assign pready       = !rd || rd_done_r;
    assign pslverr      = 1'b0;
    assign prdata       = prdata_r;
    assign sys_rst_o    = sys_rst_r;
    assign cpu_run_o    = !sys_rst_r;
    assign fetch_addr_o = vec_r;
    assign fetch_load_o = load_r;
    assign ram_clear_o  = 1'b0;
    assign sfr_reset_o  = sys_rst_r;
    assign ale_pull_o   = sys_rst_r;
    assign prog_store_enable_n_pull_o = sys_rst_r;
    assign port_pull_o  = st_r != rbc_pkg::RBC_ST_RUN;
    assign bod_irq_o    = bod_pend_r;
    assign irq_o        = |(istat_r & imask_r);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_start_vector: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(sys_rst_r) |-> fetch_load_o && fetch_addr_o == `RBC_RESET_VEC)
        else $error("reset release without vector 0000");
    a_pull_high: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sys_rst_o |-> ale_pull_o && prog_store_enable_n_pull_o)
        else $error("strobes not pulled during reset");
    a_ram_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sys_rst_o |-> !ram_clear_o)
        else $error("ram cleared by reset");
    a_iea_restore: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(sys_rst_r) |-> iea_r == 8'h00)
        else $error("sfr not restored");
    a_pof_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        por_s |=> power_control_reg_r[`RBC_BIT_POF])
        else $error("power-on flag not set");
    a_soft_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        soft_req && st_r == rbc_pkg::RBC_ST_RUN |=> sys_rst_r)
        else $error("soft reset not taken");
    a_keep_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sys_rst_r && !por_s && !wr |=> flash_config_reg_r[1] == $past(flash_config_reg_r[1]) && watchdog_control_reg_r[2] == $past(watchdog_control_reg_r[2]))
        else $error("preserved bits changed");
    a_bod_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bod_hit && !brownout_irq_enable && st_r == rbc_pkg::RBC_ST_RUN && !por_s |=> sys_rst_r)
        else $error("brown-out did not reset");
    a_bod_vector: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bod_irq && !any_rst && st_r == rbc_pkg::RBC_ST_RUN |=> fetch_addr_o == `RBC_BOD_VEC
        ##0 bod_irq_o)
        else $error("brown-out interrupt missing");
    a_pin_width: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(pin_ok_r) |-> pin_cnt_r == `RBC_RST_CLKS)
        else $error("pin reset accepted too early");
    a_bod_keeps_run: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st_r == rbc_pkg::RBC_ST_RUN && bod_hit && brownout_irq_enable && !pin_ok_r && !por_s && !soft_req
        |=> cpu_run_o)
        else $error("brown-out interrupt stopped the processor");
    a_ebo_clear_rst: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(brownout_irq_enable) && bod_hit && st_r == rbc_pkg::RBC_ST_RUN |=> sys_rst_r)
        else $error("enable cleared during brown-out without reset");
    a_port_pull: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sys_rst_o |-> port_pull_o)
        else $error("port pins not pulled during reset");

    c_por: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $fell(sys_rst_r));
    c_soft: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) soft_req);
    c_bod_irq: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) bod_irq);
    c_bod_rst: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) ev[`RBC_EV_BOD_RST]);
    c_read_wait: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) rd && pready);
endmodule
